/* File: inc/pfc_gate_pkg.sv */
// Purpose: shared constants and types for the gate protection logic
// Assumes: 40 MHz clock, comparator results already digitised and synchronous
// Notes:   all times are converted to clock cycles here
//
// Operation
// RULE_01: min-off pulse clears both latches, top priority
// RULE_02: peak limit turns gate off for cycle
// RULE_03: timing allows 95 percent duty at 65 kHz
// RULE_04: peak limit trips at threshold every cycle
// RULE_05: peak limit acts only after deglitch time
// RULE_06: brownout enables above high, faults below low
// RULE_07: filtered brownout stops gate, restart above high
// RULE_08: filtered open loop powers down, restarts above threshold
// RULE_09: overvoltage turns the gate off immediately
// RULE_10: filtered overvoltage holds off until release level
// RULE_11: gate active high, low during supply lockout
// RULE_12: cycle opens with gate off, ramp discharged
// RULE_13: start needs supply, feedback and brownout all good
// RULE_14: soft start ramps until output release fraction
// RULE_15: gate is latch gated by every fault
`default_nettype none
package pfc_gate_pkg;

    localparam int CLK_HZ          = 40_000_000;
    localparam int SWITCH_HZ       = 65_000;
    localparam int MAX_DUTY_PCT    = 95;
    localparam int MIN_OFF_NS      = 600;
    localparam int PEAK_FILTER_NS  = 200;
    localparam int BROWN_FILTER_US = 20;
    localparam int LOOP_FILTER_US  = 1;
    localparam int OVP_FILTER_US   = 12;
    localparam int SS_STEP_NS      = 6400;
    localparam int CLK_PER_US      = CLK_HZ / 1_000_000;

    localparam int CNT_W = 10;
    localparam int SS_W  = 8;

    localparam logic [CNT_W-1:0] PERIOD_CYC     = CNT_W'(CLK_HZ / SWITCH_HZ);
    localparam logic [CNT_W-1:0] MAX_ON_CYC     =
        CNT_W'((CLK_HZ / SWITCH_HZ) * MAX_DUTY_PCT / 100);
    localparam logic [CNT_W-1:0] ON_ALLOW_CYC   = PERIOD_CYC - MAX_ON_CYC;
    localparam logic [CNT_W-1:0] MIN_OFF_CYC    =
        CNT_W'((MIN_OFF_NS * CLK_PER_US + 999) / 1000);
    localparam logic [CNT_W-1:0] PEAK_FILTER_CYC =
        CNT_W'((PEAK_FILTER_NS * CLK_PER_US + 999) / 1000);
    localparam logic [CNT_W-1:0] BROWN_FILTER_CYC = CNT_W'(BROWN_FILTER_US * CLK_PER_US);
    localparam logic [CNT_W-1:0] LOOP_FILTER_CYC = CNT_W'(LOOP_FILTER_US * CLK_PER_US);
    localparam logic [CNT_W-1:0] OVP_FILTER_CYC = CNT_W'(OVP_FILTER_US * CLK_PER_US);
    localparam logic [CNT_W-1:0] SS_STEP_CYC    = CNT_W'(SS_STEP_NS * CLK_PER_US / 1000);
    localparam logic [CNT_W-1:0] CNT_RESET      = 10'h000;

    localparam logic [SS_W-1:0]  SS_LEVEL_RESET = 8'h00;
    localparam logic [SS_W-1:0]  SS_LEVEL_MAX   = 8'hFF;

    // digitised comparator results, one bit each
    typedef struct packed {
        logic current_limit;   // current sense at or below negative limit
        logic vin_above_high;  // brownout sense above upper threshold
        logic vin_below_low;   // brownout sense below lower threshold
        logic open_loop;       // feedback below open-loop threshold
        logic overvoltage;     // feedback above over-voltage reference
        logic ov_release;      // feedback below over-voltage release level
    } sense_cmp_type;

    typedef struct packed {
        logic peak_current_limit;
        logic input_brownout;
        logic open_loop_fault;
        logic output_overvoltage_fault;
    } fault_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SOFT_START,
        ST_REGULATE
    } run_state_type;

endpackage : pfc_gate_pkg
`default_nettype wire

/* File: rtl/deglitch_filter.sv */
// Purpose: persistence filter for one comparator result
// Assumes: raw is synchronous to clk
// Notes:   filt rises the edge after raw was high for HOLD_CYC samples
`timescale 1ns/10ps
`default_nettype none
module deglitch_filter #(
    parameter logic [pfc_gate_pkg::CNT_W-1:0] HOLD_CYC = 10'h001
) (
    // clock and reset
    input  wire logic clk,
    input  wire logic rst_b,
    // comparator
    input  wire logic raw,
    output var  logic filt
);

    logic [pfc_gate_pkg::CNT_W-1:0] cnt_q;
    logic [pfc_gate_pkg::CNT_W-1:0] cnt_d;
    logic                           filt_d;

    // any low sample restarts the count, so short glitches never pass
    assign cnt_d  = !raw ? pfc_gate_pkg::CNT_RESET :
                    (cnt_q == HOLD_CYC) ? cnt_q : cnt_q + 10'h001;
    assign filt_d = raw && (cnt_q >= HOLD_CYC - 10'h001);

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_q <= pfc_gate_pkg::CNT_RESET;
            filt  <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            filt  <= filt_d;
        end
    end

    filter_drops_a: assert property (@(posedge clk) disable iff (!rst_b) // RULE_05
        !raw |=> !filt)
        else $error("filter output held after input fell");

endmodule : deglitch_filter
`default_nettype wire

/* File: rtl/pfc_gate_protection_logic.sv */
// Purpose: final gate logic of the boost converter with fault protection
// Assumes: comparator inputs synchronous to clk; clk is the oscillator clock
// Notes:   gate_out lags its causes by one clock, which the min-off window covers
`timescale 1ns/10ps
`default_nettype none
module pfc_gate_protection_logic (
    // clock and reset
    input  wire logic                              clk,
    input  wire logic                              rst_b,
    // comparator results
    input  wire pfc_gate_pkg::sense_cmp_type       sense_in,
    input  wire logic                              ramp_cross_in,
    // supply and output level status
    input  wire logic                              supply_above_on,
    input  wire logic                              supply_below_lockout,
    input  wire logic                              output_at_release,
    // gate and ramp control
    output var  logic                              gate_out,
    output var  logic                              min_off_pulse,
    // status
    output var  pfc_gate_pkg::fault_type           fault_out,
    output var  logic                              soft_start_active,
    output var  logic [pfc_gate_pkg::SS_W-1:0]     soft_start_level,
    output var  logic                              gate_enabled
);

    logic [pfc_gate_pkg::CNT_W-1:0] cnt_q;
    logic [pfc_gate_pkg::CNT_W-1:0] cnt_d;
    logic [pfc_gate_pkg::CNT_W-1:0] ss_cnt_q;
    logic [pfc_gate_pkg::CNT_W-1:0] ss_cnt_d;
    logic [pfc_gate_pkg::SS_W-1:0]  ss_level_d;
    pfc_gate_pkg::run_state_type    state_q;
    pfc_gate_pkg::run_state_type    state_d;
    logic                           pwm_on_q;
    logic                           pwm_on_d;
    logic                           peak_q;
    logic                           peak_d;
    logic                           brown_q;
    logic                           brown_d;
    logic                           loop_q;
    logic                           loop_d;
    logic                           ovp_q;
    logic                           ovp_d;
    logic                           gate_d;
    logic                           peak_filt;
    logic                           brown_filt;
    logic                           loop_filt;
    logic                           ovp_filt;
    logic                           fault_any;
    logic                           running;
    logic                           start_ok;
    logic                           ss_step;

    // persistence filters for each fault comparator
    deglitch_filter #(.HOLD_CYC(pfc_gate_pkg::PEAK_FILTER_CYC)) peak_filter ( // RULE_05
        .clk  (clk),
        .rst_b(rst_b),
        .raw  (sense_in.current_limit),
        .filt (peak_filt)
    );
    deglitch_filter #(.HOLD_CYC(pfc_gate_pkg::BROWN_FILTER_CYC)) brown_filter (
        .clk  (clk),
        .rst_b(rst_b),
        .raw  (sense_in.vin_below_low),
        .filt (brown_filt)
    );
    deglitch_filter #(.HOLD_CYC(pfc_gate_pkg::LOOP_FILTER_CYC)) loop_filter (
        .clk  (clk),
        .rst_b(rst_b),
        .raw  (sense_in.open_loop),
        .filt (loop_filt)
    );
    deglitch_filter #(.HOLD_CYC(pfc_gate_pkg::OVP_FILTER_CYC)) ovp_filter (
        .clk  (clk),
        .rst_b(rst_b),
        .raw  (sense_in.overvoltage),
        .filt (ovp_filt)
    );

    // switching period; each cycle opens with the min-off window
    assign cnt_d         = (cnt_q == pfc_gate_pkg::PERIOD_CYC - 10'h001) ?
                           pfc_gate_pkg::CNT_RESET : cnt_q + 10'h001;
    assign min_off_pulse = cnt_q < pfc_gate_pkg::MIN_OFF_CYC;  // RULE_12

    // min-off clears both latches ahead of any set; an early ramp crossing
    // before the duty window is ignored so on-time never exceeds the maximum
    assign pwm_on_d = min_off_pulse ? 1'b0 :                            // RULE_01
                      (ramp_cross_in && cnt_q >= pfc_gate_pkg::ON_ALLOW_CYC) ? 1'b1 : // RULE_03
                      pwm_on_q;
    assign peak_d   = min_off_pulse ? 1'b0 : (peak_filt | peak_q); // RULE_01 RULE_04

    // fault latches: a set in the same cycle as the release condition wins
    assign brown_d = brown_filt | (brown_q & ~sense_in.vin_above_high); // RULE_06 RULE_07
    assign loop_d  = loop_filt | (loop_q & sense_in.open_loop);         // RULE_08
    assign ovp_d   = ovp_filt | (ovp_q & ~sense_in.ov_release);         // RULE_10

    assign fault_any = brown_q | loop_q | ovp_q;
    assign running   = state_q != pfc_gate_pkg::ST_IDLE;
    assign start_ok  = supply_above_on && !sense_in.open_loop       // RULE_13
                       && sense_in.vin_above_high && !brown_q && !loop_q;

    // raw over-voltage and filtered peak limit act without waiting for a latch
    assign gate_d = pwm_on_q & ~min_off_pulse & ~peak_q & ~peak_filt // RULE_02
                    & ~sense_in.overvoltage                          // RULE_09
                    & ~fault_any & running                           // RULE_15
                    & ~supply_below_lockout;                         // RULE_11

    always_comb begin
        state_d = state_q;
        case (state_q)
            pfc_gate_pkg::ST_IDLE: begin
                if (start_ok) begin
                    state_d = pfc_gate_pkg::ST_SOFT_START;
                end
            end
            pfc_gate_pkg::ST_SOFT_START: begin
                if (brown_q || loop_q) begin
                    state_d = pfc_gate_pkg::ST_IDLE;
                end else if (output_at_release) begin
                    state_d = pfc_gate_pkg::ST_REGULATE;          // RULE_14
                end
            end
            pfc_gate_pkg::ST_REGULATE: begin
                if (brown_q || loop_q) begin
                    state_d = pfc_gate_pkg::ST_IDLE;              // RULE_07 RULE_08
                end
            end
            default: begin
                state_d = pfc_gate_pkg::ST_IDLE;
            end
        endcase
        if (supply_below_lockout) begin
            state_d = pfc_gate_pkg::ST_IDLE;                      // RULE_11
        end
    end

    // soft-start level climbs one step per interval; any restart begins at zero
    assign ss_step    = ss_cnt_q == pfc_gate_pkg::SS_STEP_CYC - 10'h001;
    assign ss_cnt_d   = (state_q != pfc_gate_pkg::ST_SOFT_START || ss_step) ?
                        pfc_gate_pkg::CNT_RESET : ss_cnt_q + 10'h001;
    assign ss_level_d = (state_q == pfc_gate_pkg::ST_IDLE) ? pfc_gate_pkg::SS_LEVEL_RESET :
                        (state_q == pfc_gate_pkg::ST_REGULATE) ? pfc_gate_pkg::SS_LEVEL_MAX :
                        (ss_step && soft_start_level != pfc_gate_pkg::SS_LEVEL_MAX) ?
                        soft_start_level + 8'h01 : soft_start_level;        // RULE_14

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            cnt_q    <= pfc_gate_pkg::CNT_RESET;
            ss_cnt_q <= pfc_gate_pkg::CNT_RESET;
            state_q  <= pfc_gate_pkg::ST_IDLE;
            pwm_on_q <= 1'b0;
            peak_q   <= 1'b0;
            brown_q  <= 1'b0;
            loop_q   <= 1'b0;
            ovp_q    <= 1'b0;
            gate_out <= 1'b0;
            soft_start_level <= pfc_gate_pkg::SS_LEVEL_RESET;
        end else begin
            cnt_q    <= cnt_d;
            ss_cnt_q <= ss_cnt_d;
            state_q  <= state_d;
            pwm_on_q <= pwm_on_d;
            peak_q   <= peak_d;
            brown_q  <= brown_d;
            loop_q   <= loop_d;
            ovp_q    <= ovp_d;
            gate_out <= gate_d;
            soft_start_level <= ss_level_d;
        end
    end

    // one driver for the whole status word, fields in declaration order
    assign fault_out = pfc_gate_pkg::fault_type'({peak_q, brown_q, loop_q, ovp_q});
    assign soft_start_active = state_q == pfc_gate_pkg::ST_SOFT_START;
    assign gate_enabled      = running;

    // checks
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    sequence peak_persists;
        sense_in.current_limit [*8];
    endsequence

    sequence idle_then_start;
        state_q == pfc_gate_pkg::ST_IDLE ##1 state_q == pfc_gate_pkg::ST_SOFT_START;
    endsequence

    min_off_clears_a: assert property ( // RULE_01
        min_off_pulse |=> !gate_out && !pwm_on_q && !peak_q)
        else $error("min-off pulse did not clear gate and latches");

    peak_holds_off_a: assert property ( // RULE_02
        peak_q |=> !gate_out)
        else $error("gate on while peak limit latched");

    duty_window_a: assert property ( // RULE_03
        gate_out |-> $past(cnt_q) >= pfc_gate_pkg::ON_ALLOW_CYC)
        else $error("gate on outside the duty window");

    peak_every_cycle_a: assert property ( // RULE_04
        peak_filt && !min_off_pulse |=> peak_q)
        else $error("peak limit not latched");

    peak_deglitch_a: assert property ( // RULE_05
        peak_persists |=> ##1 !gate_out)
        else $error("persistent peak current did not stop gate");

    brown_restart_a: assert property ( // RULE_07
        $fell(brown_q) |-> $past(sense_in.vin_above_high))
        else $error("brownout released without upper threshold");

    loop_power_down_a: assert property ( // RULE_08
        loop_q |=> state_q == pfc_gate_pkg::ST_IDLE && !gate_out)
        else $error("open loop did not power down");

    ovp_immediate_a: assert property ( // RULE_09
        sense_in.overvoltage |=> !gate_out)
        else $error("gate on during over-voltage");

    ovp_hold_a: assert property ( // RULE_10
        ovp_q && !sense_in.ov_release |=> ovp_q && !gate_out)
        else $error("over-voltage hold released early");

    lockout_low_a: assert property ( // RULE_11
        supply_below_lockout |=> !gate_out && state_q == pfc_gate_pkg::ST_IDLE)
        else $error("gate not forced low in lockout");

    min_off_width_a: assert property ( // RULE_12
        $fell(min_off_pulse) |-> $past(cnt_q) == pfc_gate_pkg::MIN_OFF_CYC - 10'h001)
        else $error("min-off window has wrong width");

    start_gate_a: assert property ( // RULE_13
        idle_then_start |-> $past(supply_above_on) && $past(sense_in.vin_above_high)
                            && !$past(sense_in.open_loop))
        else $error("start without supply, feedback or brownout good");

    ss_rising_a: assert property ( // RULE_14
        soft_start_active |=> soft_start_level >= $past(soft_start_level))
        else $error("soft-start level fell while active");

    fault_gating_a: assert property ( // RULE_15
        gate_out |-> $past(pwm_on_q) && !$past(fault_any) && $past(running))
        else $error("gate on without latch or with a fault");

endmodule : pfc_gate_protection_logic
`default_nettype wire

/* File: bench/boost_stage_model.sv */
// Purpose: behavioural boost switch, inductor current and sense dividers
// Assumes: bench sets the knobs; comparator levels synchronous to clk
// Notes:   over-current only shows while the switch conducts
`timescale 1ns/10ps
`default_nettype none
module boost_stage_model (
    // clock
    input  wire logic                        clk,
    // switch side
    input  wire logic                        gate_out,
    input  wire logic                        min_off_pulse,
    // scenario knobs
    input  wire logic [1:0]                  vin_lvl,
    input  wire logic [1:0]                  fb_lvl,
    input  wire logic [9:0]                  ilim_at,
    input  wire logic [9:0]                  ilim_len,
    input  wire logic [9:0]                  cross_dly,
    // comparator results
    output var  pfc_gate_pkg::sense_cmp_type sense_in,
    output var  logic                        ramp_cross_in
);
    logic [9:0] on_q;
    logic [9:0] ramp_q;

    // the current collapses as soon as the switch opens, so a trip ends itself
    always_ff @(posedge clk) begin
        on_q   <= gate_out ? on_q + 10'h001 : 10'h000;
        ramp_q <= min_off_pulse ? 10'h000 : ramp_q + 10'h001;
    end

    always_comb begin
        sense_in.current_limit  = gate_out && on_q >= ilim_at && on_q < ilim_at + ilim_len;
        sense_in.vin_above_high = vin_lvl == 2'h2;
        sense_in.vin_below_low  = vin_lvl == 2'h0;
        sense_in.open_loop      = fb_lvl == 2'h0;
        sense_in.overvoltage    = fb_lvl == 2'h3;
        sense_in.ov_release     = fb_lvl <= 2'h1;
        // slow loop answers by a longer crossing delay
        ramp_cross_in           = !min_off_pulse && ramp_q >= cross_dly;
    end
endmodule : boost_stage_model
`default_nettype wire

/* File: bench/pfc_gate_protection_logic_tb_top.sv */
// Purpose: self-checking bench for the gate protection logic
// Assumes: 40 MHz clock, switching period 615 cycles
// Notes:   the boost stage model makes all comparator levels
`timescale 1ns/10ps
`default_nettype none
module pfc_gate_protection_logic_tb_top;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic supply_above_on = 1'b0;
    logic supply_below_lockout = 1'b0;
    logic output_at_release = 1'b0;
    logic [1:0] vin_lvl = 2'h2;
    logic [1:0] fb_lvl = 2'h1;
    logic [9:0] ilim_at = 10'h000;
    logic [9:0] ilim_len = 10'h000;
    logic [9:0] cross_dly = 10'h000;
    pfc_gate_pkg::sense_cmp_type sense_in;
    pfc_gate_pkg::fault_type fault_out;
    logic ramp_cross_in, gate_out, min_off_pulse, soft_start_active, gate_enabled;
    logic [7:0] soft_start_level;
    int err_total = 0;
    int n_tests = 0;
    int c, g, mo, ov;
    logic pk;

    always #12.5 clk = ~clk;

    pfc_gate_protection_logic i_pfc_gate_protection_logic (.clk(clk), .rst_b(rst_b),
        .sense_in(sense_in), .ramp_cross_in(ramp_cross_in), .supply_above_on(supply_above_on),
        .supply_below_lockout(supply_below_lockout), .output_at_release(output_at_release),
        .gate_out(gate_out), .min_off_pulse(min_off_pulse), .fault_out(fault_out),
        .soft_start_active(soft_start_active), .soft_start_level(soft_start_level),
        .gate_enabled(gate_enabled));
    boost_stage_model i_boost_stage_model (.clk(clk), .gate_out(gate_out),
        .min_off_pulse(min_off_pulse), .vin_lvl(vin_lvl), .fb_lvl(fb_lvl), .ilim_at(ilim_at),
        .ilim_len(ilim_len), .cross_dly(cross_dly), .sense_in(sense_in),
        .ramp_cross_in(ramp_cross_in));

    task automatic close_out;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : close_out
    task automatic fail(input string m);
        err_total++;
        $display("FAIL %0t %s", $time, m);
    endtask : fail
    task automatic chk_bit(input logic got, input logic exp, input string m);
        n_tests++;
        if (got !== exp) fail(m);
    endtask : chk_bit
    task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp, input string m);
        n_tests++;
        if (got !== exp) fail(m);
    endtask : chk_vec
    task automatic chk_rng(input int got, input int lo, input int hi, input string m);
        n_tests++;
        if (got < lo || got > hi) fail(m);
    endtask : chk_rng
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // bounded wait; running out ends the run
    task automatic wait_on(ref logic s, input logic v, input int lim, input string m);
        int k;
        k = 0;
        while (s !== v && k < lim) begin
            tick(1);
            k++;
        end
        chk_bit(s, v, m);
        if (s !== v) close_out();
    endtask : wait_on
    task automatic count_hi(ref logic s, input int n, output int cnt);
        cnt = 0;
        repeat (n) begin
            tick(1);
            cnt += (s === 1'b1);
        end
    endtask : count_hi
    // one switching period, aligned to the start of the min-off window
    task automatic period(output int gn, output int mn, output int on, output logic lim);
        wait_on(min_off_pulse, 1'b0, 700, "min-off stuck");
        wait_on(min_off_pulse, 1'b1, 700, "period missing");
        gn = 0;
        mn = 0;
        on = 0;
        lim = 1'b0;
        repeat (int'(pfc_gate_pkg::PERIOD_CYC)) begin
            gn += (gate_out === 1'b1);
            mn += (min_off_pulse === 1'b1);
            on += (gate_out === 1'b1 && min_off_pulse === 1'b1);
            lim |= fault_out.peak_current_limit;
            tick(1);
        end
    endtask : period

    task automatic t_reset;
        chk_bit(gate_out, 1'b0, "gate on in reset");
        chk_bit(min_off_pulse, 1'b1, "no min-off after reset");
        chk_vec({4'h0, fault_out}, 8'h00, "fault after reset");
        chk_vec(soft_start_level, 8'h00, "level after reset");
    endtask : t_reset
    task automatic t_start;
        logic [7:0] l1;
        tick(50);
        chk_bit(gate_enabled, 1'b0, "enabled without supply");
        @(posedge clk) begin
            supply_above_on <= 1'b1;
            fb_lvl <= 2'h0;
        end
        tick(20);
        chk_bit(gate_enabled, 1'b0, "enabled with open loop");
        @(posedge clk) fb_lvl <= 2'h1;
        tick(3);
        chk_bit(soft_start_active, 1'b1, "no soft start");
        tick(300);
        l1 = soft_start_level;
        tick(600);
        chk_bit(soft_start_level > l1, 1'b1, "level not rising");
        @(posedge clk) output_at_release <= 1'b1;
        tick(3);
        chk_bit(soft_start_active, 1'b0, "soft start not released");
        chk_bit(gate_enabled, 1'b1, "not regulating");
    endtask : t_start
    task automatic t_duty;
        period(g, mo, ov, pk);
        chk_rng(mo, 24, 24, "min-off width");
        chk_rng(ov, 0, 1, "gate inside min-off");
        chk_rng(g, 578, 584, "max duty");
        @(posedge clk) cross_dly <= 10'h12C;
        period(g, mo, ov, pk);
        period(g, mo, ov, pk);
        chk_rng(g, 283, 297, "ramp crossing ignored");
        @(posedge clk) cross_dly <= 10'h000;
    endtask : t_duty
    task automatic t_peak;
        @(posedge clk) begin
            ilim_at <= 10'h032;
            ilim_len <= 10'h064;
        end
        period(g, mo, ov, pk);
        repeat (2) begin
            period(g, mo, ov, pk);
            chk_rng(g, 57, 62, "peak limit not cutting");
            chk_bit(pk, 1'b1, "peak limit missed");
        end
        @(posedge clk) ilim_len <= 10'h007;
        period(g, mo, ov, pk);
        period(g, mo, ov, pk);
        chk_bit(pk, 1'b0, "glitch tripped or latch stuck");
        chk_rng(g, 578, 584, "glitch cut gate");
        @(posedge clk) ilim_len <= 10'h000;
    endtask : t_peak
    task automatic t_ovp;
        wait_on(gate_out, 1'b1, 700, "gate idle");
        @(posedge clk) fb_lvl <= 2'h3;
        tick(2);
        chk_bit(gate_out, 1'b0, "overvoltage not immediate");
        count_hi(gate_out, 500, c);
        chk_rng(c, 0, 0, "gate during overvoltage");
        chk_bit(fault_out.output_overvoltage_fault, 1'b1, "overvoltage fault");
        @(posedge clk) fb_lvl <= 2'h2;
        count_hi(gate_out, 700, c);
        chk_rng(c, 0, 0, "released above release level");
        @(posedge clk) fb_lvl <= 2'h1;
        wait_on(gate_out, 1'b1, 700, "no resume");
        chk_bit(fault_out.output_overvoltage_fault, 1'b0, "overvoltage stuck");
    endtask : t_ovp
    task automatic t_brown;
        @(posedge clk) vin_lvl <= 2'h1;
        wait_on(gate_out, 1'b1, 700, "stopped in band");
        @(posedge clk) vin_lvl <= 2'h0;
        tick(790);
        chk_bit(fault_out.input_brownout, 1'b0, "brownout early");
        tick(20);
        chk_bit(fault_out.input_brownout, 1'b1, "brownout missed");
        chk_bit(gate_enabled, 1'b0, "running in brownout");
        chk_bit(gate_out, 1'b0, "gate in brownout");
        @(posedge clk) begin
            vin_lvl <= 2'h1;
            output_at_release <= 1'b0;
        end
        count_hi(gate_enabled, 300, c);
        chk_rng(c, 0, 0, "restart below upper");
        @(posedge clk) vin_lvl <= 2'h2;
        tick(4);
        chk_bit(soft_start_active, 1'b1, "no soft restart");
        @(posedge clk) output_at_release <= 1'b1;
        tick(3);
    endtask : t_brown
    task automatic t_loop;
        @(posedge clk) fb_lvl <= 2'h0;
        tick(30);
        @(posedge clk) fb_lvl <= 2'h1;
        tick(2);
        chk_bit(gate_enabled, 1'b1, "short open loop tripped");
        @(posedge clk) fb_lvl <= 2'h0;
        tick(45);
        chk_bit(fault_out.open_loop_fault, 1'b1, "open loop missed");
        chk_bit(gate_enabled, 1'b0, "no power down");
        @(posedge clk) fb_lvl <= 2'h1;
        tick(4);
        chk_bit(gate_enabled, 1'b1, "no restart");
    endtask : t_loop
    task automatic t_lock;
        wait_on(gate_out, 1'b1, 700, "gate idle");
        @(posedge clk) supply_below_lockout <= 1'b1;
        tick(2);
        chk_bit(gate_out, 1'b0, "gate in lockout");
        count_hi(gate_out, 700, c);
        chk_rng(c, 0, 0, "lockout not held");
        @(posedge clk) supply_below_lockout <= 1'b0;
    endtask : t_lock

    initial begin
        repeat (16) @(posedge clk);
        rst_b <= 1'b1;
        tick(1);
        t_reset();
        t_start();
        t_duty();
        t_peak();
        t_ovp();
        t_brown();
        t_loop();
        t_lock();
        close_out();
    end
endmodule : pfc_gate_protection_logic_tb_top
`default_nettype wire
